// *** tb/dsp_dual_bus_opcode_decoder_assertions.sv ***
// Port-level checks of the dual-bus opcode decoder, bound to its top module.
`timescale 1ns/1ps
module dsp_dec_checker #(
  parameter int PC_W = 14
) (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              rst_n,
  // Fetch port and decoded word.
  input wire logic [PC_W-1:0]   pm_addr,
  input wire logic              pm_rd,
  input wire logic [23:0]       pm_data,
  input wire dsp_dec_pkg::dec_t dec,
  input wire logic              dec_valid
);
  //==============================================================================
  // All checks share the fetch clock and sleep while reset is held.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_reset_pc;
    $rose(rst_n) |-> pm_addr == dsp_dec_pkg::RESET_PC && !pm_rd;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("fetch not parked at word 4");
  property p_reserved;
    pm_rd && (pm_data[23:22] == 2'b00 || pm_data[23:20] == 4'h4) |=>
      dec_valid && dec.itype == dsp_dec_pkg::IT_RESERVED;
  endproperty
  a_reserved: assert property (p_reserved) else $error("unknown word not reserved");
  property p_dual;
    pm_rd && pm_data[23:22] == 2'b11 |=> dec.itype == dsp_dec_pkg::IT_DUAL_READ && dec.pm_index == $past(pm_data[7:6]);
  endproperty
  a_dual: assert property (p_dual) else $error("dual read decode wrong");
  property p_imm;
    pm_rd && pm_data[23:21] == 3'b101 |=> dec.itype == dsp_dec_pkg::IT_DM_IMM && dec.imm_data == $past(pm_data[19:4]);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate write decode wrong");
  property p_direct;
    pm_rd && pm_data[23:21] == 3'b100 |=>
      dec.itype == dsp_dec_pkg::IT_DM_DIRECT && dec.direct_addr == $past(pm_data[17:4]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct transfer decode wrong");
  property p_alu_dm;
    pm_rd && pm_data[23:21] == 3'b011 |=>
      dec.itype == dsp_dec_pkg::IT_ALU_DM && dec.data_reg_sel == $past(pm_data[7:4]);
  endproperty
  a_alu_dm: assert property (p_alu_dm) else $error("data transfer decode wrong");
  property p_alu_pm;
    pm_rd && pm_data[23:20] == 4'h5 |=> dec.itype == dsp_dec_pkg::IT_ALU_PM && dec.dir_write == $past(pm_data[19]);
  endproperty
  a_alu_pm: assert property (p_alu_pm) else $error("program transfer decode wrong");
  property p_round;
    pm_rd && pm_data[23:22] == 2'b11 |=> dec.round_modifier == ($past(pm_data[17:13]) == dsp_dec_pkg::FN_MAC_ROUND);
  endproperty
  a_round: assert property (p_round) else $error("rounding flag wrong");
  // Decoded fields may only move on a fetch, so the datapath never sees a half-changed word.
  property p_hold;
    !pm_rd |=> !dec_valid && $stable(dec);
  endproperty
  a_hold: assert property (p_hold) else $error("decode moved without a fetch");
endmodule : dsp_dec_checker

bind dsp_dual_bus_opcode_decoder dsp_dec_checker #(.PC_W(PC_W)) i_dsp_dec_checker (.clk, .rst_n, .pm_addr, .pm_rd,
  .pm_data, .dec, .dec_valid);

// *** tb/prog_mem_model.sv ***
// Program memory model that answers the decoder's fetch port.
`timescale 1ns/1ps
module prog_mem_model (
  // Clock.
  input wire logic        clk,
  // Fetch port.
  input wire logic [13:0] pm_addr,
  input wire logic        pm_rd,
  output logic     [23:0] pm_data
);
  // Word store loaded by the bench; addresses wrap on 256 words.
  logic [23:0] mem [0:255];
  logic [23:0] last = 24'h0;
  // Outside a fetch the bus shows the inverse of the last word, so a late sample cannot pass.
  always_comb pm_data = pm_rd ? mem[pm_addr[7:0]] : ~last;
  // Remember the word of each fetch.
  always @(posedge clk) begin
    if (pm_rd) last <= mem[pm_addr[7:0]];
  end
endmodule : prog_mem_model

// *** tb/tb_dsp_dual_bus_opcode_decoder.sv ***
// Self-checking bench for the dual-bus opcode decoder.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_dsp_dual_bus_opcode_decoder;
  //==============================================================================
  // Signals and scoreboard state.
  logic              clk = 1'b0, rst_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, pm_rd, dec_valid;
  logic [7:0]        wb_adr = 8'h00;
  logic [3:0]        wb_sel = 4'hf;
  logic [31:0]       wb_dat_w = 32'h0, wb_dat_r, q, seed = 32'h9f9a;
  logic [13:0]       pm_addr, dm_addr;
  logic [23:0]       pm_data;
  dsp_dec_pkg::dec_t dec, e, m;
  int                n_fail = 0, check_count = 0, cyc_n = 0, da = 0, base = 0, len = 0, step = 0, mk, p, k;
  int                fa[$], ft[$];
  logic [23:0]       fw[$];
  int                ea[7] = '{0, 1, 2, 2, 2, 2, 3};
  int                eg[6] = '{1, 1, 2, 1, 1, 1};

  always #12.5 clk = ~clk;

  dsp_dual_bus_opcode_decoder i_dsp_dual_bus_opcode_decoder (.clk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
    .wb_dat_w, .wb_dat_r, .wb_ack, .pm_addr, .pm_rd, .pm_data, .dec, .dec_valid, .dm_addr);
  prog_mem_model i_prog_mem_model (.clk, .pm_addr, .pm_rd, .pm_data);

  //==============================================================================
  // Helpers: random words, expected decode, field mask, bus cycle, verdict.
  function logic [23:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[23:0];
  endfunction : xorshift
  // Fields a type does not carry stay zero; the mask below hides them.
  function automatic dsp_dec_pkg::dec_t xdec(input logic [23:0] w);
    dsp_dec_pkg::dec_t x;
    x = '0;
    if (w[23:22] == 2'b11) begin
      x.itype = dsp_dec_pkg::IT_DUAL_READ;
      x.dual_access = 1'b1;
      {x.pm_dest_sel, x.dm_dest_sel, x.alu_mac_function, x.y_operand_sel, x.x_operand_sel, x.pm_index, x.pm_modify,
        x.dm_index, x.dm_modify} = w[21:0];
    end else if (w[23:21] == 3'b101) begin
      x.itype = dsp_dec_pkg::IT_DM_IMM;
      {x.gen_sel, x.imm_data, x.dm_index, x.dm_modify} = w[20:0];
    end else if (w[23:21] == 3'b100) begin
      x.itype = dsp_dec_pkg::IT_DM_DIRECT;
      {x.dir_write, x.reg_group, x.direct_addr, x.data_reg_sel} = w[20:0];
    end else if (w[23:21] == 3'b011) begin
      x.itype = dsp_dec_pkg::IT_ALU_DM;
      {x.gen_sel, x.dir_write, x.result_dest, x.alu_mac_function, x.y_operand_sel, x.x_operand_sel,
        x.data_reg_sel, x.dm_index, x.dm_modify} = w[20:0];
    end else if (w[23:20] == 4'b0101) begin
      x.itype = dsp_dec_pkg::IT_ALU_PM;
      {x.dir_write, x.result_dest, x.alu_mac_function, x.y_operand_sel, x.x_operand_sel, x.data_reg_sel,
        x.pm_index, x.pm_modify} = w[19:0];
    end
    x.round_modifier = x.alu_mac_function == dsp_dec_pkg::FN_MAC_ROUND;
    return x;
  endfunction : xdec
  // Operand bits below the opcode pattern; flipping them reveals which fields a type carries.
  function automatic logic [23:0] flip(input logic [23:0] w);
    return w[23:22] == 2'b11 ? 24'h3fffff : (w[23] | w[21]) ? 24'h1fffff : w[22] ? 24'h0fffff : 24'h0;
  endfunction : flip
  // One classic single cycle; the request stands until ack is sampled high, and only the watchdog ends a hang.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb
  task automatic summarize();
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  //==============================================================================
  // Score each decoded word and address step, then log each fetch with its cycle.
  always @(posedge clk) begin
    cyc_n++;
    if (rst_n && dec_valid === 1'b1) begin
      e = xdec(fw[$]);
      m = dsp_dec_pkg::dec_t'(e ^ xdec(fw[$] ^ flip(fw[$])));
      m.itype = dsp_dec_pkg::itype_t'(3'h7);
      m.dual_access = 1'b1;
      m.round_modifier = |m.alu_mac_function;
      `CHK(dec & m, e & m)
      if (e.itype inside {dsp_dec_pkg::IT_DUAL_READ, dsp_dec_pkg::IT_DM_IMM, dsp_dec_pkg::IT_ALU_DM})
        da = len != 0 ? base + (da - base + step) % len : (da + step) & 32'h3fff;
      `CHK(dm_addr, 14'(da))
    end
    if (rst_n && pm_rd === 1'b1) begin
      fa.push_back(int'(pm_addr));
      ft.push_back(cyc_n);
      fw.push_back(pm_data);
    end
  end

  //==============================================================================
  // Main sequence: registers, random program, interrupts, then a cached loop.
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, dsp_dec_pkg::REG_STATUS, 32'h0);
    `CHK(q[29:16], dsp_dec_pkg::RESET_PC)
    wb(1'b1, 8'h30, 32'h5a5a);
    wb(1'b0, 8'h30, 32'h0);
    `CHK(q, 32'h0)
    for (k = 0; k < 256; k++) i_prog_mem_model.mem[k] = xorshift();
    i_prog_mem_model.mem[4] = 24'hc02000;
    i_prog_mem_model.mem[5] = 24'h606000;
    base = 32'h20;
    len = 5;
    step = 3;
    da = base;
    wb(1'b1, dsp_dec_pkg::REG_DINDEX, 32'h20);
    wb(1'b1, dsp_dec_pkg::REG_DLEN, 32'h5);
    wb(1'b1, dsp_dec_pkg::REG_DMOD, 32'h3);
    wb(1'b1, dsp_dec_pkg::REG_CTRL, 32'h1);
    k = 0;
    while (fa.size() < 60 && k < 400) begin
      @(posedge clk);
      k++;
    end
    wb(1'b1, dsp_dec_pkg::REG_CTRL, 32'h0);
    `CHK(fa.size() >= 60, 1'b1)
    `CHK(fa[0], 4)
    for (k = 0; k < fa.size() - 1; k++) `CHK(ft[k + 1] - ft[k], fw[k][23:22] == 2'b11 ? 2 : 1)
    // Two pending lines: the lower one is served first, then the other, then fetch runs on.
    wb(1'b1, dsp_dec_pkg::REG_CTRL, 32'h1);
    mk = fa.size();
    wb(1'b1, dsp_dec_pkg::REG_IRQ, 32'ha);
    repeat (12) @(posedge clk);
    k = mk;
    while (k < fa.size() - 3 && fa[k] != 1) k++;
    `CHK(fa[k], 1)
    `CHK(fa[k + 1], 3)
    `CHK(fa[k + 2], 4)
    wb(1'b1, dsp_dec_pkg::REG_CTRL, 32'h0);
    wb(1'b0, dsp_dec_pkg::REG_IRQ, 32'h0);
    `CHK(q[3:0], 4'h0)
    // One-word loop on a dual-access word: only the first pass pays the stall.
    wb(1'b0, dsp_dec_pkg::REG_STATUS, 32'h0);
    p = int'(q[29:16]);
    for (k = 0; k < 4; k++) i_prog_mem_model.mem[p + k] = k == 2 ? 24'hc02000 : 24'h000000;
    len = 0;
    wb(1'b1, dsp_dec_pkg::REG_DLEN, 32'h0);
    wb(1'b1, dsp_dec_pkg::REG_LTOP, p + 2);
    wb(1'b1, dsp_dec_pkg::REG_LEND, p + 2);
    wb(1'b1, dsp_dec_pkg::REG_LCOUNT, 32'h4);
    mk = fa.size();
    wb(1'b1, dsp_dec_pkg::REG_CTRL, 32'h3);
    repeat (12) @(posedge clk);
    wb(1'b1, dsp_dec_pkg::REG_CTRL, 32'h0);
    for (k = 0; k < 7; k++) `CHK(fa[mk + k], p + ea[k])
    for (k = 0; k < 6; k++) `CHK(ft[mk + k + 1] - ft[mk + k], eg[k])
    summarize();
  end

  // A hung handshake ends the run here; a stalled fetch only runs out the 400-cycle wait.
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule : tb_dsp_dual_bus_opcode_decoder

// *** verilog/dsp_dec_pkg.sv ***
// Package with constants, types and register map for the dual-bus opcode decoder.
//==============================================================================
// Overview of operation
// - A 24-bit word that matches no known pattern is flagged reserved and starts no operation.
// - Top bits 11 give an ALU/MAC with dual memory read and its nine fields.
// - Top bits 101 give an immediate data memory write with generator, value, index and modifier.
// - Top bits 100 give a direct-address data memory transfer with direction, group, address and register.
// - Top bits 011 give an ALU/MAC with a data memory transfer and its fields.
// - Top bits 0101 give an ALU/MAC with a program memory transfer and its fields.
// - A serviced interrupt n sends fetch to program memory word n, one of the lowest four.
// - After reset fetch begins at program memory address 004.
// - A non-zero length wraps post-modified addresses inside the buffer; zero length is linear.
// - An instruction touching both memories costs one extra cycle before the next fetch.
// - Inside a loop a cached dual-access instruction runs again without that extra cycle.
// - The rounding modifier on a MAC asks for a rounded result; signed-by-signed does not round.
package dsp_dec_pkg;
  //==============================================================================
  // Register map, byte addresses on the bus.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INSTR  = 8'h08;
  localparam logic [7:0] REG_FIELDS = 8'h0c;
  localparam logic [7:0] REG_IMM    = 8'h10;
  localparam logic [7:0] REG_LTOP   = 8'h14;
  localparam logic [7:0] REG_LEND   = 8'h18;
  localparam logic [7:0] REG_LCOUNT = 8'h1c;
  localparam logic [7:0] REG_IRQ    = 8'h20;
  localparam logic [7:0] REG_DINDEX = 8'h24;
  localparam logic [7:0] REG_DLEN   = 8'h28;
  localparam logic [7:0] REG_DMOD   = 8'h2c;
  // Control bits and reset values.
  localparam int          CTRL_RUN  = 0;
  localparam int          CTRL_LOOP = 1;
  localparam logic [13:0] RESET_PC  = 14'h0004;
  localparam int          NUM_VEC   = 4;
  // Opcode patterns on the top bits.
  localparam logic [1:0] OP_DUAL   = 2'h3;
  localparam logic [2:0] OP_DM_IMM = 3'h5;
  localparam logic [2:0] OP_DM_DIR = 3'h4;
  localparam logic [2:0] OP_ALU_DM = 3'h3;
  localparam logic [3:0] OP_ALU_PM = 4'h5;
  // Function codes that carry the rounding and signed-by-signed modifiers.
  localparam logic [4:0] FN_MAC_ROUND = 5'h01;
  localparam logic [4:0] FN_MAC_SS  = 5'h03;

  typedef enum logic [2:0] {IT_RESERVED, IT_DUAL_READ, IT_DM_IMM, IT_DM_DIRECT, IT_ALU_DM, IT_ALU_PM} itype_t;

  typedef struct packed {
    itype_t      itype;
    logic [1:0]  pm_dest_sel;
    logic [1:0]  dm_dest_sel;
    logic [4:0]  alu_mac_function;
    logic [1:0]  y_operand_sel;
    logic [2:0]  x_operand_sel;
    logic [1:0]  pm_index;
    logic [1:0]  pm_modify;
    logic [1:0]  dm_index;
    logic [1:0]  dm_modify;
    logic        gen_sel;
    logic        dir_write;
    logic        result_dest;
    logic [3:0]  data_reg_sel;
    logic [1:0]  reg_group;
    logic [15:0] imm_data;
    logic [13:0] direct_addr;
    logic        round_modifier;
    logic        dual_access;
  } dec_t;
endpackage : dsp_dec_pkg

// *** verilog/dsp_dual_bus_opcode_decoder.sv ***
// Instruction fetch, opcode decode, address generator and Wishbone registers of the decoder.
`timescale 1ns/1ps
module dsp_dual_bus_opcode_decoder #(
  parameter int PC_W  = 14,
  parameter int DAG_W = 14
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Wishbone classic slave.
  input  wire logic                 wb_cyc,
  input  wire logic                 wb_stb,
  input  wire logic                 wb_we,
  input  wire logic [7:0]           wb_adr,
  input  wire logic [3:0]           wb_sel,
  input  wire logic [31:0]          wb_dat_w,
  output logic      [31:0]          wb_dat_r,
  output logic                      wb_ack,
  // Program memory fetch port.
  output logic      [PC_W-1:0]      pm_addr,
  output logic                      pm_rd,
  input  wire logic [23:0]          pm_data,
  // Decoded instruction towards datapath and memories.
  output dsp_dec_pkg::dec_t         dec,
  output logic                      dec_valid,
  output logic      [DAG_W-1:0]     dm_addr
);

  //==============================================================================
  // Elaboration checks.
  if (PC_W != 14) begin : g_bad_pc
    $error("PC_W must be 14 to hold the reset and vector addresses.");
  end
  if (DAG_W < 2 || DAG_W > 16) begin : g_bad_dag
    $error("DAG_W must lie between 2 and 16.");
  end

  // Number of interrupt lines, one pending bit each.
  localparam int NUM_VEC_W = dsp_dec_pkg::NUM_VEC;

  //==============================================================================
  // State.
  logic                   run;
  logic                   loop_active;
  logic [PC_W-1:0]        pc;
  logic [PC_W-1:0]        loop_top;
  logic [PC_W-1:0]        loop_end;
  logic [15:0]            loop_count_reg;
  logic [23:0]            instr;
  logic                   stall;
  logic                   cache_valid;
  logic [PC_W-1:0]        cache_addr;
  logic [NUM_VEC_W-1:0]   irq_pending;
  logic [DAG_W-1:0]       dag_index;
  logic [DAG_W-1:0]       dag_base;
  logic [DAG_W-1:0]       dag_len;
  logic [DAG_W-1:0]       dag_mod;
  logic                   reserved_seen;

  //==============================================================================
  // Decode of one word; pure function of the bits.
  function automatic dsp_dec_pkg::dec_t decode(input logic [23:0] w);
    dsp_dec_pkg::dec_t d;
    d = '0;
    d.itype = dsp_dec_pkg::IT_RESERVED;
    if (w[23:22] == dsp_dec_pkg::OP_DUAL) begin
      d.itype            = dsp_dec_pkg::IT_DUAL_READ;
      d.pm_dest_sel      = w[21:20];
      d.dm_dest_sel      = w[19:18];
      d.alu_mac_function = w[17:13];
      d.y_operand_sel    = w[12:11];
      d.x_operand_sel    = w[10:8];
      d.pm_index         = w[7:6];
      d.pm_modify        = w[5:4];
      d.dm_index         = w[3:2];
      d.dm_modify        = w[1:0];
      d.dual_access      = 1'b1;
    end else if (w[23:21] == dsp_dec_pkg::OP_DM_IMM) begin
      d.itype     = dsp_dec_pkg::IT_DM_IMM;
      d.gen_sel   = w[20];
      d.imm_data  = w[19:4];
      d.dm_index  = w[3:2];
      d.dm_modify = w[1:0];
      d.dir_write = 1'b1;
    end else if (w[23:21] == dsp_dec_pkg::OP_DM_DIR) begin
      d.itype        = dsp_dec_pkg::IT_DM_DIRECT;
      d.dir_write    = w[20];
      d.reg_group    = w[19:18];
      d.direct_addr  = w[17:4];
      d.data_reg_sel = w[3:0];
    end else if (w[23:21] == dsp_dec_pkg::OP_ALU_DM) begin
      d.itype            = dsp_dec_pkg::IT_ALU_DM;
      d.gen_sel          = w[20];
      d.dir_write        = w[19];
      d.result_dest      = w[18];
      d.alu_mac_function = w[17:13];
      d.y_operand_sel    = w[12:11];
      d.x_operand_sel    = w[10:8];
      d.data_reg_sel     = w[7:4];
      d.dm_index         = w[3:2];
      d.dm_modify        = w[1:0];
    end else if (w[23:20] == dsp_dec_pkg::OP_ALU_PM) begin
      d.itype            = dsp_dec_pkg::IT_ALU_PM;
      d.dir_write        = w[19];
      d.result_dest      = w[18];
      d.alu_mac_function = w[17:13];
      d.y_operand_sel    = w[12:11];
      d.x_operand_sel    = w[10:8];
      d.data_reg_sel     = w[7:4];
      d.pm_index         = w[3:2];
      d.pm_modify        = w[1:0];
    end
    // Only the rounding code asks for rounding; signed-by-signed leaves it clear.
    d.round_modifier = (d.itype != dsp_dec_pkg::IT_RESERVED) && (d.itype != dsp_dec_pkg::IT_DM_IMM) &&
                       (d.itype != dsp_dec_pkg::IT_DM_DIRECT) &&
                       (d.alu_mac_function == dsp_dec_pkg::FN_MAC_ROUND);
    return d;
  endfunction : decode

  //==============================================================================
  // Fetch control and bus decode.
  dsp_dec_pkg::dec_t next_dec;
  logic              fetch;
  logic              cache_hit;
  logic              wb_req;
  logic              wb_wr;
  logic              dm_step;
  logic [NUM_VEC_W-1:0] irq_set;
  logic [DAG_W-1:0]  next_index;

  assign next_dec  = decode(pm_data);
  // No fetch in the cycle after a dual-access word that misses the loop cache; the memories are still busy.
  assign fetch     = run && !stall;
  assign pm_rd     = fetch;
  assign pm_addr   = pc;
  assign cache_hit = loop_active && cache_valid && (cache_addr == pc);
  assign wb_req    = wb_cyc && wb_stb && !wb_ack;
  assign wb_wr     = wb_req && wb_we && wb_sel[0];
  assign dm_step   = fetch && ((next_dec.itype == dsp_dec_pkg::IT_DUAL_READ) ||
                               (next_dec.itype == dsp_dec_pkg::IT_DM_IMM) ||
                               (next_dec.itype == dsp_dec_pkg::IT_ALU_DM));
  assign irq_set   = (wb_wr && wb_adr == dsp_dec_pkg::REG_IRQ) ? wb_dat_w[NUM_VEC_W-1:0] : '0;
  assign dm_addr   = dag_index;

  //==============================================================================
  // Post-modify with modulus wrap; the trade-off is a single index register.
  always_comb begin
    logic [DAG_W:0] sum;
    logic [DAG_W:0] top;
    sum = {1'b0, dag_index} + {1'b0, dag_mod};
    top = {1'b0, dag_base} + {1'b0, dag_len};
    next_index = sum[DAG_W-1:0];
    if (dag_len != '0) begin
      if (dag_mod[DAG_W-1] && (sum[DAG_W-1:0] < dag_base)) begin
        next_index = DAG_W'(sum[DAG_W-1:0] + dag_len);
      end else if (!dag_mod[DAG_W-1] && (sum >= top)) begin
        next_index = DAG_W'(sum[DAG_W-1:0] - dag_len);
      end
    end
  end

  //==============================================================================
  // Run enable; the loop enable sits with the program counter.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run <= 1'b0;
    end else if (wb_wr && wb_adr == dsp_dec_pkg::REG_CTRL) begin
      run <= wb_dat_w[dsp_dec_pkg::CTRL_RUN];
    end
  end

  //==============================================================================
  // Program counter, interrupt vectoring and hardware loop.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc             <= dsp_dec_pkg::RESET_PC;
      irq_pending    <= '0;
      loop_active    <= 1'b0;
      loop_count_reg <= '0;
    end else begin
      if (wb_wr && wb_adr == dsp_dec_pkg::REG_LCOUNT) begin
        loop_count_reg <= wb_dat_w[15:0];
      end
      if (wb_wr && wb_adr == dsp_dec_pkg::REG_CTRL) begin
        loop_active <= wb_dat_w[dsp_dec_pkg::CTRL_LOOP];
      end
      // A new request in the servicing cycle stays pending.
      irq_pending <= irq_pending | irq_set;
      if (fetch) begin
        if (irq_pending != '0) begin
          for (int i = NUM_VEC_W - 1; i >= 0; i--) begin
            if (irq_pending[i]) begin
              pc <= PC_W'(i);
            end
          end
          irq_pending <= (irq_pending & (irq_pending - 1'b1)) | irq_set;
        end else if (loop_active && pc == loop_end && loop_count_reg > 16'h0001) begin
          pc             <= loop_top;
          loop_count_reg <= loop_count_reg - 16'h0001;
        end else begin
          pc <= pc + 1'b1;
          if (loop_active && pc == loop_end) begin
            loop_active    <= 1'b0;
            loop_count_reg <= '0;
          end
        end
      end
    end
  end

  //==============================================================================
  // Loop bounds.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_top <= '0;
      loop_end <= '0;
    end else if (wb_wr && wb_adr == dsp_dec_pkg::REG_LTOP) begin
      loop_top <= wb_dat_w[PC_W-1:0];
    end else if (wb_wr && wb_adr == dsp_dec_pkg::REG_LEND) begin
      loop_end <= wb_dat_w[PC_W-1:0];
    end
  end

  //==============================================================================
  // Decode register: fields leave together with the word that made them.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      instr         <= '0;
      dec           <= '0;
      dec_valid     <= 1'b0;
      reserved_seen <= 1'b0;
    end else begin
      dec_valid <= fetch;
      if (fetch) begin
        instr         <= pm_data;
        dec           <= next_dec;
        reserved_seen <= (next_dec.itype == dsp_dec_pkg::IT_RESERVED);
      end
    end
  end

  //==============================================================================
  // Dual-access stall and the one-entry loop cache.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stall       <= 1'b0;
      cache_valid <= 1'b0;
      cache_addr  <= '0;
    end else begin
      stall <= fetch && next_dec.dual_access && !cache_hit;
      if (!loop_active) begin
        cache_valid <= 1'b0;
      end else if (fetch && next_dec.dual_access && !cache_hit) begin
        cache_valid <= 1'b1;
        cache_addr  <= pc;
      end
    end
  end

  //==============================================================================
  // Address generator registers; a bus write wins over a step.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dag_index <= '0;
      dag_base  <= '0;
      dag_len   <= '0;
      dag_mod   <= '0;
    end else begin
      if (wb_wr && wb_adr == dsp_dec_pkg::REG_DINDEX) begin
        dag_index <= wb_dat_w[DAG_W-1:0];
        dag_base  <= wb_dat_w[DAG_W-1:0];
      end else if (dm_step) begin
        dag_index <= next_index;
      end
      if (wb_wr && wb_adr == dsp_dec_pkg::REG_DLEN) begin
        dag_len <= wb_dat_w[DAG_W-1:0];
      end
      if (wb_wr && wb_adr == dsp_dec_pkg::REG_DMOD) begin
        dag_mod <= wb_dat_w[DAG_W-1:0];
      end
    end
  end

  //==============================================================================
  // Wishbone answer: one wait state, unmapped reads return zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= '0;
    end else begin
      wb_ack   <= wb_req;
      wb_dat_r <= '0;
      if (wb_req && !wb_we) begin
        case (wb_adr)
          dsp_dec_pkg::REG_CTRL:   wb_dat_r <= {30'h0, loop_active, run};
          dsp_dec_pkg::REG_STATUS: wb_dat_r <= {2'h0, pc, 10'h0, cache_valid, stall, reserved_seen, dec.itype};
          dsp_dec_pkg::REG_INSTR:  wb_dat_r <= {8'h0, instr};
          dsp_dec_pkg::REG_FIELDS: wb_dat_r <= {dec.pm_dest_sel, dec.dm_dest_sel, dec.alu_mac_function,
                                                dec.y_operand_sel, dec.x_operand_sel, dec.pm_index,
                                                dec.pm_modify, dec.dm_index, dec.dm_modify, dec.gen_sel,
                                                dec.dir_write, dec.result_dest, dec.data_reg_sel,
                                                dec.reg_group, dec.round_modifier};
          dsp_dec_pkg::REG_IMM:    wb_dat_r <= {2'h0, dec.direct_addr, dec.imm_data};
          dsp_dec_pkg::REG_LTOP:   wb_dat_r <= 32'(loop_top);
          dsp_dec_pkg::REG_LEND:   wb_dat_r <= 32'(loop_end);
          dsp_dec_pkg::REG_LCOUNT: wb_dat_r <= {16'h0, loop_count_reg};
          dsp_dec_pkg::REG_IRQ:    wb_dat_r <= 32'(irq_pending);
          dsp_dec_pkg::REG_DINDEX: wb_dat_r <= 32'(dag_index);
          dsp_dec_pkg::REG_DLEN:   wb_dat_r <= 32'(dag_len);
          dsp_dec_pkg::REG_DMOD:   wb_dat_r <= 32'(dag_mod);
          default:                 wb_dat_r <= '0;
        endcase
      end
    end
  end

endmodule : dsp_dual_bus_opcode_decoder
